//--- rtl/ica_pkg.sv
`default_nettype none

package ica_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ---------------------------------------------------------------
  localparam logic [7:0] ICA_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ICA_OFF_STATUS = 8'h04;
  localparam logic [7:0] ICA_OFF_MASK   = 8'h08;
  localparam logic [7:0] ICA_OFF_PRIO   = 8'h0C;
  localparam logic [7:0] ICA_OFF_LEVEL  = 8'h10;
  localparam logic [7:0] ICA_OFF_PORT0  = 8'h14;
  localparam logic [7:0] ICA_OFF_PORT1  = 8'h18;
  localparam logic [7:0] ICA_OFF_TAKE   = 8'h1C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ICA_CTRL_FP_BIT = 0;
  localparam int ICA_CTRL_EE_BIT = 1;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic       ICA_RST_FP    = 1'b0;
  localparam logic       ICA_RST_EE    = 1'b0;
  localparam logic [7:0] ICA_RST_MASK  = 8'h00;
  localparam logic [3:0] ICA_RST_LEVEL = 4'h0;

  // ---------------------------------------------------------------
  // Cause codes presented with a taken interrupt
  // ---------------------------------------------------------------
  localparam logic [3:0] ICA_CAUSE_RESET = 4'hF;
  localparam logic [3:0] ICA_CAUSE_ASYNC = 4'hE;

  typedef enum logic [1:0] {
    ICA_IDLE,
    ICA_DRAIN,
    ICA_FLUSH
  } ica_state_t;

endpackage : ica_pkg

`default_nettype wire

//--- rtl/ica_core.sv
`timescale 1ns/1ns
`default_nettype none

module ica_core
  import ica_pkg::*;
#(
  parameter int EXT_N = 4
) (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System sources (asynchronous pins)
  input  wire logic [EXT_N-1:0]  ext_src,
  input  wire logic              helper_core_irq,
  input  wire logic              flow_controller_irq,
  input  wire logic              sys_reset_req,
  // Instruction pipeline
  input  wire logic              sync_exc_valid,
  input  wire logic [3:0]        sync_exc_cause,
  input  wire logic [31:0]       sync_exc_pc,
  input  wire logic              sync_exc_fetch_exec,
  input  wire logic              sync_exc_fp,
  output logic                   sync_exc_ready,
  input  wire logic [31:0]       oldest_pc,
  input  wire logic              pipe_drained,
  // Interrupt take
  output logic                   hold_issue,
  output logic                   flush_prefetch,
  output logic                   take_valid,
  output logic      [3:0]        take_cause,
  output logic                   take_precise,
  output logic                   take_sync_class,
  output logic      [31:0]       take_resume_pc,
  output logic                   fp_exec_enable,
  output logic      [1:0]        thread_irq,
  output logic                   irq
);

  localparam int SRC_N = EXT_N + 4;
  localparam int PIN_N = EXT_N + 3;
  localparam int HELP  = EXT_N;
  localparam int FLOW  = EXT_N + 1;
  localparam int SW0   = EXT_N + 2;
  localparam int SW1   = EXT_N + 3;

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_sync_b;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // -----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // -----------------------------------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] pin_f;
  logic [PIN_N-1:0] pin_rise;

  assign pin_raw = {sys_reset_req, flow_controller_irq, helper_core_irq,
                    ext_src};

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else if (ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  wire [PIN_N-1:0] next_pin_f = (pin_s2 & pin_s3) |
                                (pin_f & (pin_s2 | pin_s3));

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_f <= '0;
    end else if (ce) begin
      pin_f <= next_pin_f;
    end
  end

  assign pin_rise = next_pin_f & ~pin_f & {PIN_N{ce}};

  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  logic             ctrl_fp;
  logic             ctrl_ee;
  logic [SRC_N-1:0] status;
  logic [SRC_N-1:0] mask;
  logic [31:0]      src_prio;
  logic [3:0]       level0;
  logic [3:0]       level1;
  logic [3:0]       cur_cause;
  logic             cur_precise;
  logic             cur_sync;
  logic             cur_fp;
  logic [31:0]      cur_pc;
  ica_state_t       state;
  logic             rst_pend;

  wire acc      = psel & penable & ce;
  wire wr_acc   = acc & pwrite;
  wire rd_acc   = acc & ~pwrite;
  wire hit_ctrl = paddr == ICA_OFF_CTRL;
  wire hit_stat = paddr == ICA_OFF_STATUS;
  wire hit_mask = paddr == ICA_OFF_MASK;
  wire hit_prio = paddr == ICA_OFF_PRIO;
  wire hit_lvl  = paddr == ICA_OFF_LEVEL;
  wire hit_p0   = paddr == ICA_OFF_PORT0;
  wire hit_p1   = paddr == ICA_OFF_PORT1;
  wire hit_take = paddr == ICA_OFF_TAKE;
  wire mapped   = hit_ctrl | hit_stat | hit_mask | hit_prio | hit_lvl |
                  hit_p0 | hit_p1 | hit_take;
  wire stat_rd  = rd_acc & hit_stat;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, ctrl_ee, ctrl_fp} :
    hit_stat ? {{(32-SRC_N){1'b0}}, status} :
    hit_mask ? {{(32-SRC_N){1'b0}}, mask} :
    hit_prio ? src_prio :
    hit_lvl  ? {24'h0, level1, level0} :
    hit_take ? {24'h0, 1'b0, cur_fp, cur_sync, cur_precise, cur_cause} :
               32'h0;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prdata <= 32'h0;
    end else if (rd_acc) begin
      prdata <= rd_mux;
    end
  end

  // -----------------------------------------------------------------
  // Sticky status, mask and thread routing
  // -----------------------------------------------------------------
  // Set wins over the clear of a status read in the same cycle
  wire [SRC_N-1:0] events = {wr_acc & hit_p1, wr_acc & hit_p0,
                             pin_rise[FLOW:0]};
  wire [SRC_N-1:0] next_status = (status & ~{SRC_N{stat_rd}}) | events;
  wire [SRC_N-1:0] live = status & mask;

  // Lower value is more urgent; a source passes below the thread level
  logic [SRC_N-1:0] ok0;
  logic [SRC_N-1:0] ok1;
  genvar gi;
  generate
    for (gi = 0; gi < SRC_N; gi++) begin : g_prio
      assign ok0[gi] = (src_prio[gi*4 +: 4] < level0) && (gi != SW1);
      assign ok1[gi] = (src_prio[gi*4 +: 4] < level1) && (gi != SW0);
    end
  endgenerate

  // The enable bit cannot single out one source, only the group
  assign thread_irq = {|(live & ok1), |(live & ok0)} & {2{ctrl_ee}};
  assign irq        = |live;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status   <= '0;
      mask     <= ICA_RST_MASK[SRC_N-1:0];
      src_prio <= 32'h0;
      level0   <= ICA_RST_LEVEL;
      level1   <= ICA_RST_LEVEL;
    end else if (ce) begin
      status <= next_status;
      if (wr_acc && hit_mask) begin
        mask <= pwdata[SRC_N-1:0];
      end
      if (wr_acc && hit_prio) begin
        src_prio <= pwdata;
      end
      if (wr_acc && hit_lvl) begin
        level0 <= pwdata[3:0];
        level1 <= pwdata[7:4];
      end
    end
  end

  // -----------------------------------------------------------------
  // Take sequencer
  // -----------------------------------------------------------------
  // Floating point is dropped while disabled, so no exception is raised
  wire sync_ok    = sync_exc_valid & (~sync_exc_fp | ctrl_fp);
  wire idle       = state == ICA_IDLE;
  wire go_reset   = idle & rst_pend;
  wire go_sync    = idle & ~rst_pend & sync_ok;
  wire go_async   = idle & ~rst_pend & ~sync_ok & thread_irq[0];
  wire go         = (go_reset | go_sync | go_async) & ce;

  assign sync_exc_ready = idle & ~rst_pend & ce;
  assign hold_issue     = state == ICA_DRAIN;
  assign flush_prefetch = (state == ICA_FLUSH) & ce;
  assign take_valid     = (state == ICA_FLUSH) & ce;
  assign fp_exec_enable = ctrl_fp;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ICA_IDLE;
    end else if (ce) begin
      unique case (state)
        ICA_IDLE: begin
          if (go) begin
            state <= ICA_DRAIN;
          end
        end
        ICA_DRAIN: begin
          if (pipe_drained) begin
            state <= ICA_FLUSH;
          end
        end
        ICA_FLUSH: begin
          state <= ICA_IDLE;
        end
      endcase
    end
  end

  // A reset request is remembered until taken; a new rise wins the clear
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rst_pend <= 1'b0;
    end else if (ce) begin
      rst_pend <= pin_rise[PIN_N-1] | (rst_pend & ~go_reset);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cur_cause   <= 4'h0;
      cur_precise <= 1'b0;
      cur_sync    <= 1'b0;
      cur_fp      <= 1'b0;
      cur_pc      <= 32'h0;
    end else if (go) begin
      cur_cause   <= go_reset ? ICA_CAUSE_RESET :
                     go_sync  ? sync_exc_cause : ICA_CAUSE_ASYNC;
      cur_sync    <= go_sync;
      cur_fp      <= go_sync & sync_exc_fp;
      // Floating point is precise whatever a mode would allow
      cur_precise <= go_sync & (sync_exc_fetch_exec | sync_exc_fp);
      cur_pc      <= go_sync ? sync_exc_pc : oldest_pc;
    end
  end

  assign take_cause      = cur_cause;
  assign take_precise    = cur_precise;
  assign take_sync_class = cur_sync;
  assign take_resume_pc  = cur_pc;

  // -----------------------------------------------------------------
  // Machine state word
  // -----------------------------------------------------------------
  // A take clears the external enable, so a level source cannot loop
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_fp <= ICA_RST_FP;
      ctrl_ee <= ICA_RST_EE;
    end else if (ce) begin
      if (wr_acc && hit_ctrl) begin
        ctrl_fp <= pwdata[ICA_CTRL_FP_BIT];
        ctrl_ee <= pwdata[ICA_CTRL_EE_BIT];
      end
      if (go) begin
        ctrl_ee <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  a_fp_always_precise: assert property (
    take_valid && cur_fp |-> take_precise)
    else $error("fp take not precise");
  a_async_imprecise: assert property (
    take_valid && !take_sync_class |-> !take_precise)
    else $error("async take marked precise");
  a_sync_precise: assert property (
    ce && go_sync && sync_exc_fetch_exec |=> cur_precise && cur_sync)
    else $error("sync exception not precise");
  a_flush_after_drain: assert property (
    $rose(state == ICA_FLUSH) |-> $past(pipe_drained) && $past(hold_issue))
    else $error("flush before drain");
  a_fp_off_dropped: assert property (
    idle && ce && !ctrl_fp && sync_exc_fp && !rst_pend && !thread_irq[0]
    |=> state == ICA_IDLE)
    else $error("fp exception taken while disabled");
  a_status_sticky: assert property (
    ce && !stat_rd |=> (status & $past(status)) == $past(status))
    else $error("status bit lost without read");
  a_ee_group_gate: assert property (
    !ctrl_ee |-> thread_irq == 2'b00)
    else $error("thread irq with enable low");
  a_level_zero_blocks: assert property (
    level0 == 4'h0 |-> !thread_irq[0])
    else $error("thread0 irq at level zero");
  a_port0_raises: assert property (
    wr_acc && hit_p0 |=> status[SW0])
    else $error("port write lost");
  a_reset_taken: assert property (
    ce && go_reset |=> cur_cause == ICA_CAUSE_RESET && state == ICA_DRAIN)
    else $error("reset request not taken");
  a_take_flushes: assert property (
    take_valid |-> flush_prefetch && !hold_issue)
    else $error("take without flush");

endmodule : ica_core

`default_nettype wire

//--- verif/ica_partner.sv
`timescale 1ns/1ns
`default_nettype none
module ica_partner (
  // Clock and core handshake
  input  wire logic        sys_clk,
  input  wire logic        sync_exc_ready,
  input  wire logic        hold_issue,
  // Pipeline offer and source pins
  output logic             sync_exc_valid,
  output logic [3:0]       sync_exc_cause,
  output logic [31:0]      sync_exc_pc,
  output logic             sync_exc_fetch_exec,
  output logic             sync_exc_fp,
  output logic             pipe_drained,
  output logic [6:0]       pins
);
  int lag = 1;
  int cnt = 0;
  initial begin
    sync_exc_valid = 1'b0;
    sync_exc_cause = 4'h0;
    sync_exc_pc = 32'h0;
    sync_exc_fetch_exec = 1'b0;
    sync_exc_fp = 1'b0;
    pins = 7'h00;
  end
  // Older instructions finish lag cycles into a drain, slow or prompt
  always @(posedge sys_clk) cnt <= hold_issue ? cnt + 1 : 0;
  assign pipe_drained = hold_issue && (cnt >= lag);
  task automatic offer(input logic [3:0] c, input logic [31:0] pc,
                       input logic fe, input logic fp);
    sync_exc_valid <= 1'b1;
    sync_exc_cause <= c;
    sync_exc_pc <= pc;
    sync_exc_fetch_exec <= fe;
    sync_exc_fp <= fp;
    @(posedge sys_clk);
    while (sync_exc_ready !== 1'b1) @(posedge sys_clk);
    // Released lines show garbage, never the stale offer
    sync_exc_valid <= 1'b0;
    sync_exc_cause <= ~c;
    sync_exc_pc <= ~pc;
    sync_exc_fetch_exec <= ~fe;
    sync_exc_fp <= ~fp;
    @(posedge sys_clk);
  endtask : offer
  // Pins are asynchronous: held long enough to pass the synchroniser
  task automatic pulse(input logic [6:0] m);
    pins <= m;
    repeat (6) @(posedge sys_clk);
    pins <= 7'h00;
    @(posedge sys_clk);
  endtask : pulse
endmodule : ica_partner
`default_nettype wire

//--- verif/test_interrupt_class_attributes.sv
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_class_attributes;
  import ica_pkg::*;
  logic        sys_clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, take_resume_pc, pc, oldest_pc;
  logic [31:0] sx_pc;
  logic [3:0]  take_cause, sx_cause, c;
  logic [1:0]  thread_irq;
  logic [6:0]  pins;
  logic        pready, pslverr, sync_exc_ready, hold_issue, irq, dr;
  logic        flush_prefetch, take_valid, take_precise, take_sync_class;
  logic        fp_exec_enable, sx_valid, sx_fe, sx_fp, pipe_drained;
  logic [32:0] rd_q[$];
  logic [37:0] tk_q[$];
  logic [7:0]  ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                         8'h18, 8'h1C, 8'h20};
  int          seed = 32'hAA397E4B;
  int          mismatches = 0;
  int          n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  ica_core #(.EXT_N(4)) i_ica_core (.sys_clk(sys_clk), .rst_b(rst_b),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_src(pins[3:0]), .helper_core_irq(pins[4]),
    .flow_controller_irq(pins[5]), .sys_reset_req(pins[6]),
    .sync_exc_valid(sx_valid), .sync_exc_cause(sx_cause),
    .sync_exc_pc(sx_pc), .sync_exc_fetch_exec(sx_fe), .sync_exc_fp(sx_fp),
    .sync_exc_ready(sync_exc_ready), .oldest_pc(oldest_pc),
    .pipe_drained(pipe_drained), .hold_issue(hold_issue),
    .flush_prefetch(flush_prefetch), .take_valid(take_valid),
    .take_cause(take_cause), .take_precise(take_precise),
    .take_sync_class(take_sync_class), .take_resume_pc(take_resume_pc),
    .fp_exec_enable(fp_exec_enable), .thread_irq(thread_irq), .irq(irq));
  ica_partner i_ica_partner (.sys_clk(sys_clk),
    .sync_exc_ready(sync_exc_ready), .hold_issue(hold_issue),
    .sync_exc_valid(sx_valid), .sync_exc_cause(sx_cause),
    .sync_exc_pc(sx_pc), .sync_exc_fetch_exec(sx_fe), .sync_exc_fp(sx_fp),
    .pipe_drained(pipe_drained), .pins(pins));
  task automatic check(input logic [37:0] got, input logic [37:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    if (!wr) rd_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wait_takes;
    int k;
    k = 0;
    while (tk_q.size() != 0 && k < 60) begin
      @(posedge sys_clk);
      k++;
    end
    check(tk_q.size(), 0, "take missing");
  endtask : wait_takes
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ----
  // Result watchers
  // ----
  always @(posedge sys_clk) begin
    logic err;
    logic [32:0] e;
    if ((psel & penable & pready & ~pwrite) === 1'b1) begin
      err = pslverr;
      e = rd_q.pop_front();
      #1;
      check({err, prdata}, e, "read");
    end
  end
  always @(posedge sys_clk) begin
    if (take_valid === 1'b1) begin
      check({flush_prefetch, hold_issue, dr}, 3'b101, "flush");
      if (tk_q.size() == 0) check(1, 0, "unexpected take");
      else check({take_cause, take_precise, take_sync_class,
                  take_resume_pc}, tk_q.pop_front(), "take");
    end
    dr <= (take_valid === 1'b1) ? 1'b0 : (dr | (pipe_drained === 1'b1));
  end
  // ----
  // Scenarios
  // ----
  initial begin
    dr = 1'b0;
    oldest_pc <= $random(seed);
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (ra[i]) apb(1'b0, ra[i], 32'h0, {ra[i] == 8'h20, 32'h0});
    apb(1'b1, ICA_OFF_PRIO, 32'h0, 33'h0);
    check(fp_exec_enable, 0, "fp off");
    $display("test reset_values done");
    // Fetch/execute and fp faults are precise; fp while disabled drops
    for (int i = 0; i < 4; i++) begin
      c = 4'($random(seed));
      pc = $random(seed);
      i_ica_partner.lag = $random(seed) & 3;
      if (i == 3) apb(1'b1, ICA_OFF_CTRL, 32'h1, 33'h0);
      if (i != 2) tk_q.push_back({c, i != 1, 1'b1, pc});
      i_ica_partner.offer(c, pc, ~i[0], i[1]);
    end
    wait_takes();
    apb(1'b0, ICA_OFF_TAKE, 32'h0, {29'h7, c});
    check(fp_exec_enable, 1, "fp on");
    $display("test sync_precision done");
    apb(1'b1, ICA_OFF_MASK, 32'h0, 33'h0);
    i_ica_partner.pulse(7'h04);
    repeat (8) @(posedge sys_clk);
    check(irq, 0, "masked");
    apb(1'b0, ICA_OFF_STATUS, 32'h0, {1'b0, 32'h4});
    apb(1'b0, ICA_OFF_STATUS, 32'h0, 33'h0);
    apb(1'b1, ICA_OFF_MASK, 32'hFF, 33'h0);
    apb(1'b1, ICA_OFF_CTRL, 32'h1, 33'h0);
    apb(1'b1, ICA_OFF_LEVEL, 32'h11, 33'h0);
    i_ica_partner.pulse(7'h01);
    repeat (8) @(posedge sys_clk);
    check({irq, thread_irq}, 3'b100, "group off");
    tk_q.push_back({ICA_CAUSE_ASYNC, 2'b00, oldest_pc});
    apb(1'b1, ICA_OFF_CTRL, 32'h3, 33'h0);
    wait_takes();
    apb(1'b0, ICA_OFF_CTRL, 32'h0, {1'b0, 32'h1});
    apb(1'b0, ICA_OFF_STATUS, 32'h0, {1'b0, 32'h1});
    $display("test external_group done");
    apb(1'b1, ICA_OFF_LEVEL, 32'h0, 33'h0);
    apb(1'b1, ICA_OFF_CTRL, 32'h3, 33'h0);
    i_ica_partner.pulse(7'h30);
    repeat (8) @(posedge sys_clk);
    check({irq, thread_irq}, 3'b100, "level zero");
    tk_q.push_back({ICA_CAUSE_ASYNC, 2'b00, oldest_pc});
    apb(1'b1, ICA_OFF_LEVEL, 32'h11, 33'h0);
    wait_takes();
    apb(1'b0, ICA_OFF_STATUS, 32'h0, {1'b0, 32'h30});
    $display("test helper_flow done");
    for (int t = 0; t < 2; t++) begin
      apb(1'b1, ICA_OFF_CTRL, 32'h3, 33'h0);
      apb(1'b1, ICA_OFF_LEVEL, t ? 32'h10 : 32'h01, 33'h0);
      if (t == 0) tk_q.push_back({ICA_CAUSE_ASYNC, 2'b00, oldest_pc});
      apb(1'b1, t ? ICA_OFF_PORT1 : ICA_OFF_PORT0, $random(seed), 33'h0);
      @(posedge sys_clk);
      if (t == 1) check(thread_irq, 2'b10, "port1");
      wait_takes();
      apb(1'b0, ICA_OFF_STATUS, 32'h0, {1'b0, 32'h40 << t});
    end
    $display("test soft_ports done");
    apb(1'b1, ICA_OFF_MASK, 32'h0, 33'h0);
    apb(1'b1, ICA_OFF_CTRL, 32'h0, 33'h0);
    tk_q.push_back({ICA_CAUSE_RESET, 2'b00, oldest_pc});
    i_ica_partner.pulse(7'h40);
    wait_takes();
    apb(1'b0, ICA_OFF_TAKE, 32'h0, {29'h0, ICA_CAUSE_RESET});
    $display("test system_reset done");
    apb(1'b1, ICA_OFF_MASK, 32'hFF, 33'h0);
    ce <= 1'b0;
    i_ica_partner.pulse(7'h08);
    ce <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(irq, 0, "ce frozen");
    apb(1'b0, ICA_OFF_STATUS, 32'h0, 33'h0);
    $display("test clock_enable done");
    print_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule : test_interrupt_class_attributes
`default_nettype wire
